// [src/codec_pkg.sv]
package codec_pkg;
	// Register offsets
	localparam logic [15:0] FIFO_PORT_ADDR   = 16'h09A6;
	localparam logic [15:0] FORMAT_ADDR      = 16'h1000;
	localparam logic [15:0] FIFO_SIZE_ADDR   = 16'h1002;
	localparam logic [15:0] CONTROL_ADDR     = 16'h1004;
	localparam logic [15:0] STATUS_ADDR      = 16'h1006;
	localparam logic [15:0] INT_EN_ADDR      = 16'h1008;
	localparam logic [15:0] THRESH_ADDR      = 16'h100A;
	// Sampling format codes
	localparam logic [1:0]  FMT_422          = 2'h0;
	localparam logic [1:0]  FMT_420          = 2'h1;
	localparam logic [1:0]  FMT_411          = 2'h2;
	localparam logic [1:0]  FMT_444          = 2'h3;
	// Encoder sources
	localparam logic [1:0]  SRC_CAMERA       = 2'h0;
	localparam logic [1:0]  SRC_DISPLAY      = 2'h1;
	localparam logic [1:0]  SRC_HOST         = 2'h2;
	// Control bit positions
	localparam int          CTL_ENABLE       = 0;
	localparam int          CTL_DECODE       = 1;
	localparam int          CTL_BYPASS       = 2;
	localparam int          CTL_SRC_LO       = 4;
	// Status bit positions
	localparam int          ST_EMPTY         = 0;
	localparam int          ST_FULL          = 1;
	localparam int          ST_THRESH        = 2;
	localparam int          ST_DONE          = 3;
	// FIFO and line buffer sizes in bytes, 4:2:2 width limit
	localparam logic [16:0] FIFO_MIN_BYTES   = 17'h01000;
	localparam logic [16:0] FIFO_MAX_BYTES   = 17'h10000;
	localparam logic [15:0] LINE_BUF_BYTES   = 16'h8000;
	localparam logic [11:0] MAX_WIDTH_422    = 12'hB40;
	// Block geometry
	localparam int          BLOCK_SAMPLES    = 64;
	// End-of-file marker word
	localparam logic [15:0] EOF_MARKER       = 16'hFFD9;
	// Reset values
	localparam logic [15:0] FIFO_SIZE_RESET  = 16'h1000;
	localparam logic [15:0] THRESH_RESET     = 16'h0800;
endpackage

// [src/codec_fifo_control.sv]
`timescale 1ns/1ps
module codec_fifo_control
	import codec_pkg::*;
#(
	parameter int FIFO_WORDS = 32768,
	parameter int LB_WORDS   = 16384
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// Host register port
	input  wire logic [15:0] reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [15:0] reg_rdata_out,
	// Source samples towards the encoder
	input  wire logic [15:0] camera_data_in,
	input  wire logic        camera_valid_in,
	input  wire logic [15:0] display_yuv_in,
	input  wire logic        display_valid_in,
	input  wire logic [15:0] host_yuv_in,
	input  wire logic        host_yuv_valid_in,
	input  wire logic [11:0] image_width_in,
	// Encoder core interface
	output logic      [15:0] enc_block_data_out,
	output logic             enc_block_valid_out,
	input  wire logic [15:0] enc_stream_in,
	input  wire logic        enc_stream_valid_in,
	// Decoder core interface
	output logic      [15:0] dec_stream_out,
	output logic             dec_stream_valid_out,
	input  wire logic        dec_stream_ready_in,
	input  wire logic [15:0] dec_block_in,
	input  wire logic        dec_block_valid_in,
	input  wire logic [1:0]  dec_file_format_in,
	input  wire logic        dec_format_valid_in,
	// View resizer output
	output logic      [15:0] view_data_out,
	output logic             view_valid_out,
	// Status and interrupt
	output logic      [1:0]  enc_format_out,
	output logic             format_error_out,
	output logic             width_error_out,
	output logic             irq_out
);
	localparam int FA = $clog2(FIFO_WORDS);
	localparam int LA = $clog2(LB_WORDS);

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_ENCODE = 4'b0010,
		ST_DECODE = 4'b0100,
		ST_END    = 4'b1000
	} mode_e;

	mode_e         mode_r;
	mode_e         mode_nxt;
	logic [15:0]   fifo_mem [FIFO_WORDS];
	logic [15:0]   lb_mem   [LB_WORDS];
	logic [FA-1:0] wr_ptr_r;
	logic [FA-1:0] rd_ptr_r;
	logic [16:0]   count_r;
	logic [15:0]   format_r;
	logic [15:0]   size_r;
	logic [15:0]   ctrl_r;
	logic [15:0]   thresh_r;
	logic [15:0]   int_en_r;
	logic [3:0]    sticky_r;
	logic [LA-1:0] lb_wr_r;
	logic [LA-1:0] lb_rd_r;
	logic [LA:0]   lb_fill_r;
	logic [LA:0]   lb_left_r;
	logic [15:0]   rdata_r;
	logic [15:0]   dec_data_r;
	logic [15:0]   enc_data_r;
	logic [15:0]   view_data_r;
	logic          dec_valid_r;
	logic          enc_valid_r;
	logic          view_valid_r;

	// Address decode
	wire           hit_port   = (reg_addr_in == FIFO_PORT_ADDR);
	wire           hit_fmt    = (reg_addr_in == FORMAT_ADDR);
	wire           hit_size   = (reg_addr_in == FIFO_SIZE_ADDR);
	wire           hit_ctrl   = (reg_addr_in == CONTROL_ADDR);
	wire           hit_stat   = (reg_addr_in == STATUS_ADDR);
	wire           hit_ien    = (reg_addr_in == INT_EN_ADDR);
	wire           hit_thr    = (reg_addr_in == THRESH_ADDR);
	wire           enabled    = ctrl_r[CTL_ENABLE];
	wire           decode_sel = ctrl_r[CTL_DECODE];
	wire           bypass_sel = ctrl_r[CTL_BYPASS];
	wire [1:0]     src_sel    = ctrl_r[CTL_SRC_LO +: 2];

	wire [16:0]    size_raw   = {size_r, 1'b0};
	wire [16:0]    cap_bytes  = (size_raw < FIFO_MIN_BYTES) ? FIFO_MIN_BYTES :
		(size_raw > FIFO_MAX_BYTES) ? FIFO_MAX_BYTES : size_raw;
	wire [FA:0]    cap_words  = (FA + 1)'(cap_bytes >> 1);

	wire           fifo_empty = (count_r == 17'h00000);
	wire           fifo_full  = (count_r >= cap_bytes);
	wire           fifo_thr   = (count_r >= {1'b0, thresh_r});

	wire [15:0]    src_data   = (src_sel == SRC_DISPLAY) ? display_yuv_in :
		(src_sel == SRC_HOST) ? host_yuv_in : camera_data_in;
	wire           src_valid  = (src_sel == SRC_DISPLAY) ? display_valid_in :
		(src_sel == SRC_HOST) ? host_yuv_valid_in : camera_valid_in;

	wire           fmt_bad    = (format_r[1:0] == FMT_444);
	wire           width_bad  = (format_r[1:0] == FMT_422) && (image_width_in > MAX_WIDTH_422);
	wire           enc_ok     = (mode_r == ST_ENCODE) && !fmt_bad && !width_bad;

	// FIFO producers and consumers
	wire           host_push  = reg_wr_in && hit_port && (mode_r == ST_DECODE);
	// raw words of the selected source bypass the encoder
	wire           raw_push   = enc_ok && bypass_sel && src_valid;
	wire           enc_push   = enc_ok && !bypass_sel && enc_stream_valid_in;
	wire           any_push   = (host_push || raw_push || enc_push) && !fifo_full;
	wire [15:0]    push_data  = host_push ? reg_wdata_in : (raw_push ? src_data : enc_stream_in);
	wire           host_pop   = reg_rd_in && hit_port && (mode_r == ST_ENCODE) && !fifo_empty;
	wire           dec_pop    = (mode_r == ST_DECODE) && !fifo_empty &&
		(!dec_valid_r || dec_stream_ready_in);
	wire           any_pop    = host_pop || dec_pop;
	wire           eof_seen   = dec_pop && (fifo_mem[rd_ptr_r] == EOF_MARKER);

	// Line buffer traffic, decoder output still taken after the marker
	wire           dec_side   = (mode_r == ST_DECODE) || (mode_r == ST_END);
	wire           lb_push    = (enc_ok && !bypass_sel && src_valid) ||
		(dec_side && dec_block_valid_in);
	wire [15:0]    lb_wdata   = dec_side ? dec_block_in : src_data;
	wire           lb_block   = (lb_fill_r >= (LA + 1)'(BLOCK_SAMPLES));
	wire           lb_start   = lb_block && (lb_left_r == '0) && (mode_r != ST_END);
	// Drain owed block words, then any tail once decode has ended
	wire           lb_pop     = (lb_left_r != '0) ||
		((mode_r == ST_END) && (lb_fill_r != '0));

	// Next mode
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			ST_IDLE:   if (enabled) mode_nxt = decode_sel ? ST_DECODE : ST_ENCODE;
			ST_ENCODE: if (!enabled) mode_nxt = ST_IDLE;
			ST_DECODE: if (eof_seen) mode_nxt = ST_END;
			ST_END:    if (!enabled) mode_nxt = ST_IDLE;
			default:   mode_nxt = ST_IDLE;
		endcase
	end

	// Mode register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) mode_r <= ST_IDLE;
		else          mode_r <= mode_nxt;
	end

	always_ff @(posedge clk_in) begin
		if (any_push) fifo_mem[wr_ptr_r] <= push_data;
	end

	// Pointer steps wrap at the configured size
	wire [FA-1:0]  wr_ptr_inc = FA'(wr_ptr_r + 1'b1);
	wire [FA-1:0]  rd_ptr_inc = FA'(rd_ptr_r + 1'b1);
	wire [FA-1:0]  wr_ptr_nxt = (wr_ptr_inc == FA'(cap_words)) ? '0 : wr_ptr_inc;
	wire [FA-1:0]  rd_ptr_nxt = (rd_ptr_inc == FA'(cap_words)) ? '0 : rd_ptr_inc;

	// Write pointer, cleared while idle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_ptr_r <= '0;
		end else if (mode_r == ST_IDLE) begin
			wr_ptr_r <= '0;
		end else if (any_push) begin
			wr_ptr_r <= wr_ptr_nxt;
		end
	end

	// Read pointer, cleared while idle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_ptr_r <= '0;
		end else if (mode_r == ST_IDLE) begin
			rd_ptr_r <= '0;
		end else if (any_pop) begin
			rd_ptr_r <= rd_ptr_nxt;
		end
	end

	// byte count, two bytes a word
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_r <= '0;
		end else if (mode_r == ST_IDLE) begin
			count_r <= '0;
		end else if (any_push && !any_pop) begin
			count_r <= count_r + 17'h00002;
		end else if (any_pop && !any_push) begin
			count_r <= count_r - 17'h00002;
		end
	end

	// Host-visible control registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			size_r   <= FIFO_SIZE_RESET;
			ctrl_r   <= '0;
			thresh_r <= THRESH_RESET;
			int_en_r <= '0;
		end else begin
			if (reg_wr_in && hit_size) size_r   <= reg_wdata_in;
			if (reg_wr_in && hit_ctrl) ctrl_r   <= reg_wdata_in;
			if (reg_wr_in && hit_thr)  thresh_r <= reg_wdata_in;
			if (reg_wr_in && hit_ien)  int_en_r <= reg_wdata_in;
		end
	end

	// format report overrides host write, also after the marker
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)                                       format_r <= '0;
		else if (dec_side && dec_format_valid_in)           format_r <= {14'h0000, dec_file_format_in};
		else if (reg_wr_in && hit_fmt)                      format_r <= {14'h0000, reg_wdata_in[1:0]};
	end

	wire [3:0] ev_set = {eof_seen, fifo_thr, fifo_full, fifo_empty};
	wire [3:0] ev_clr = (reg_wr_in && hit_stat) ? reg_wdata_in[3:0] : 4'h0;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) sticky_r <= '0;
		else          sticky_r <= (sticky_r & ~ev_clr) | ev_set;
	end

	// block path to encoder carries selected source
	always_ff @(posedge clk_in) begin
		if (lb_push) lb_mem[lb_wr_r] <= lb_wdata;
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			lb_wr_r   <= '0;
			lb_rd_r   <= '0;
			lb_fill_r <= '0;
		end else begin
			if (lb_push) lb_wr_r <= LA'(lb_wr_r + 1'b1);
			if (lb_pop)  lb_rd_r <= LA'(lb_rd_r + 1'b1);
			if (lb_push && !lb_pop)      lb_fill_r <= (LA + 1)'(lb_fill_r + 1'b1);
			else if (lb_pop && !lb_push) lb_fill_r <= (LA + 1)'(lb_fill_r - 1'b1);
		end
	end

	// count out one whole block per start
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			lb_left_r <= '0;
		end else if (lb_start) begin
			lb_left_r <= (LA + 1)'(BLOCK_SAMPLES);
		end else if (lb_left_r != '0) begin
			lb_left_r <= (LA + 1)'(lb_left_r - 1'b1);
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			enc_data_r   <= '0;
			enc_valid_r  <= 1'b0;
			view_data_r  <= '0;
			view_valid_r <= 1'b0;
		end else begin
			enc_valid_r  <= lb_pop && (mode_r == ST_ENCODE);
			view_valid_r <= lb_pop && (mode_r != ST_ENCODE);
			if (lb_pop) enc_data_r  <= lb_mem[lb_rd_r];
			if (lb_pop) view_data_r <= lb_mem[lb_rd_r];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			dec_data_r  <= '0;
			dec_valid_r <= 1'b0;
		end else if (dec_pop) begin
			dec_data_r  <= fifo_mem[rd_ptr_r];
			dec_valid_r <= 1'b1;
		end else if (dec_stream_ready_in) begin
			dec_valid_r <= 1'b0;
		end
	end

	wire [15:0] status_word = {12'h000, sticky_r[3] | (mode_r == ST_END), fifo_thr, fifo_full,
		fifo_empty};
	wire [15:0] read_mux = hit_port ? (fifo_empty ? 16'h0000 : fifo_mem[rd_ptr_r]) :
		hit_fmt  ? format_r :
		hit_size ? size_r :
		hit_ctrl ? ctrl_r :
		hit_stat ? (status_word | {12'h000, sticky_r}) :
		hit_ien  ? int_en_r :
		hit_thr  ? thresh_r : 16'h0000;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)       rdata_r <= '0;
		else if (reg_rd_in) rdata_r <= read_mux;
	end

	// Outputs
	assign reg_rdata_out        = rdata_r;
	assign enc_block_data_out   = enc_data_r;
	assign enc_block_valid_out  = enc_valid_r;
	assign dec_stream_out       = dec_data_r;
	assign dec_stream_valid_out = dec_valid_r;
	assign view_data_out        = view_data_r;
	assign view_valid_out       = view_valid_r;
	assign enc_format_out       = format_r[1:0];
	assign format_error_out     = (mode_r == ST_ENCODE) && fmt_bad;
	assign width_error_out      = (mode_r == ST_ENCODE) && width_bad;
	assign irq_out              = |(sticky_r & int_en_r[3:0]);
endmodule

// [bench/codec_checker.sv]
`timescale 1ns/1ps
module codec_checker
	import codec_pkg::*;
(
	// Clock, reset and register port
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	// Decoder stream and status
	input wire logic [11:0] image_width_in,
	input wire logic [15:0] dec_stream_out,
	input wire logic        dec_stream_valid_out,
	input wire logic        dec_stream_ready_in,
	input wire logic [1:0]  dec_file_format_in,
	input wire logic        dec_format_valid_in,
	input wire logic [1:0]  enc_format_out,
	input wire logic        format_error_out,
	input wire logic        width_error_out
);
	// Decode helpers
	wire logic       mapped;
	wire logic [1:0] wr_fmt;
	assign mapped = reg_addr_in inside {FIFO_PORT_ADDR, FORMAT_ADDR, FIFO_SIZE_ADDR,
		CONTROL_ADDR, STATUS_ADDR, INT_EN_ADDR, THRESH_ADDR};
	assign wr_fmt = reg_wdata_in[1:0];
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_rd_hold;
		!reg_rd_in |=> $stable(reg_rdata_out);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without a read");
	property p_unmapped;
		reg_rd_in && !mapped |=> reg_rdata_out == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_dec_hold;
		dec_stream_valid_out && !dec_stream_ready_in |=> dec_stream_valid_out && $stable(dec_stream_out);
	endproperty
	a_dec_hold: assert property (p_dec_hold)
		else $error("stream word dropped while stalled");
	property p_eof_end;
		dec_stream_valid_out && dec_stream_ready_in && dec_stream_out == EOF_MARKER
			|=> (!dec_stream_valid_out) [*2];
	endproperty
	a_eof_end: assert property (p_eof_end)
		else $error("stream continued after end marker");
	property p_fmt_dec;
		dec_format_valid_in |=> enc_format_out == $past(dec_file_format_in);
	endproperty
	a_fmt_dec: assert property (p_fmt_dec)
		else $error("decoded format not reported");
	property p_fmt_host;
		reg_wr_in && reg_addr_in == FORMAT_ADDR && !dec_format_valid_in
			|=> enc_format_out == $past(wr_fmt);
	endproperty
	a_fmt_host: assert property (p_fmt_host)
		else $error("format write not taken");
	property p_fmt_err;
		reg_wr_in && reg_addr_in == FORMAT_ADDR && wr_fmt != FMT_444 && !dec_format_valid_in
			|=> !format_error_out;
	endproperty
	a_fmt_err: assert property (p_fmt_err)
		else $error("format error on a valid code");
	property p_width;
		enc_format_out == FMT_422 && image_width_in <= MAX_WIDTH_422 |-> !width_error_out;
	endproperty
	a_width: assert property (p_width)
		else $error("legal width flagged");
endmodule

// [bench/dec_core_model.sv]
`timescale 1ns/1ps
module dec_core_model
	import codec_pkg::*;
(
	// Clock and bench controls
	input  wire logic        clk_in,
	input  wire logic        slow_in,
	input  wire logic [1:0]  file_fmt_in,
	// Compressed words from the FIFO
	input  wire logic [15:0] stream_in,
	input  wire logic        stream_valid_in,
	output logic             ready_out,
	// Decoded samples and format report
	output logic      [15:0] block_out,
	output logic             block_valid_out,
	output logic      [1:0]  fmt_out,
	output logic             fmt_valid_out
);
	logic [15:0] got_q[$];
	logic [1:0]  stall_r = 2'h0;
	wire  logic  take;
	// Slow mode stalls three cycles per word
	assign ready_out = !slow_in || stall_r == 2'h3;
	assign take = stream_valid_in && ready_out;
	initial begin
		block_out = 16'h0000;
		block_valid_out = 1'b0;
		fmt_out = 2'h0;
		fmt_valid_out = 1'b0;
	end
	always @(posedge clk_in) begin
		stall_r <= take ? 2'h0 : stall_r + {1'b0, stream_valid_in};
		block_valid_out <= take;
		fmt_valid_out <= take && stream_in == EOF_MARKER;
		block_out <= take ? stream_in ^ 16'h5A5A : ~block_out;
		fmt_out <= take ? file_fmt_in : ~fmt_out;
		if (take) begin
			got_q.push_back(stream_in);
		end
	end
endmodule

// [bench/jpeg_codec_fifo_control_tb.sv]
`timescale 1ns/1ps
module jpeg_codec_fifo_control_tb
	import codec_pkg::*;
;
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] mask;
		logic [15:0] exp;
	} row_s;
	row_s        rows[9] = '{
		'{1'b0, FIFO_SIZE_ADDR, 16'h0000, 16'hFFFF, FIFO_SIZE_RESET},
		'{1'b0, THRESH_ADDR, 16'h0000, 16'hFFFF, THRESH_RESET},
		'{1'b0, FORMAT_ADDR, 16'h0000, 16'h0003, 16'h0000},
		'{1'b0, STATUS_ADDR, 16'h0000, 16'h0001, 16'h0001},
		'{1'b0, 16'h1010, 16'h0000, 16'hFFFF, 16'h0000},
		'{1'b1, THRESH_ADDR, 16'h0010, 16'hFFFF, 16'h0010},
		'{1'b1, FORMAT_ADDR, 16'h0001, 16'h0003, 16'h0001},
		'{1'b1, FORMAT_ADDR, 16'h0002, 16'h0003, 16'h0002},
		'{1'b1, FORMAT_ADDR, 16'h0000, 16'h0003, 16'h0000}};
	logic [15:0] dec_words[3] = '{16'h1111, 16'h2222, EOF_MARKER};
	// Design inputs
	logic        clk_in = 1'b0, reset_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic        camera_valid_in = 1'b0, display_valid_in = 1'b0, host_yuv_valid_in = 1'b0;
	logic        enc_stream_valid_in = 1'b0, slow = 1'b0;
	logic [15:0] reg_addr_in = 16'h0000, reg_wdata_in = 16'h0000, enc_stream_in = 16'h0000;
	logic [15:0] camera_data_in = 16'h0000, display_yuv_in = 16'h0000, host_yuv_in = 16'h0000;
	logic [11:0] image_width_in = 12'h008;
	logic [1:0]  file_fmt = FMT_444;
	// Design outputs and partner nets
	logic [15:0] reg_rdata_out, enc_block_data_out, dec_stream_out, view_data_out, dec_block_in;
	logic        enc_block_valid_out, dec_stream_valid_out, dec_stream_ready_in, irq_out;
	logic        dec_block_valid_in, dec_format_valid_in, view_valid_out;
	logic        format_error_out, width_error_out;
	logic [1:0]  dec_file_format_in, enc_format_out;
	int          error_cnt = 0, comparisons = 0, cycles = 0, blk_cnt = 0, view_cnt = 0, n, b0;
	logic [15:0] d, view_last = 16'h0000;
	always #2.5 clk_in = ~clk_in;
	codec_fifo_control #(.FIFO_WORDS(64), .LB_WORDS(128)) u_dut (
		.clk_in(clk_in), .reset_in(reset_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.camera_data_in(camera_data_in), .camera_valid_in(camera_valid_in),
		.display_yuv_in(display_yuv_in), .display_valid_in(display_valid_in),
		.host_yuv_in(host_yuv_in), .host_yuv_valid_in(host_yuv_valid_in),
		.image_width_in(image_width_in),
		.enc_block_data_out(enc_block_data_out), .enc_block_valid_out(enc_block_valid_out),
		.enc_stream_in(enc_stream_in), .enc_stream_valid_in(enc_stream_valid_in),
		.dec_stream_out(dec_stream_out), .dec_stream_valid_out(dec_stream_valid_out),
		.dec_stream_ready_in(dec_stream_ready_in),
		.dec_block_in(dec_block_in), .dec_block_valid_in(dec_block_valid_in),
		.dec_file_format_in(dec_file_format_in), .dec_format_valid_in(dec_format_valid_in),
		.view_data_out(view_data_out), .view_valid_out(view_valid_out),
		.enc_format_out(enc_format_out), .format_error_out(format_error_out),
		.width_error_out(width_error_out), .irq_out(irq_out));
	dec_core_model u_dec (.clk_in(clk_in), .slow_in(slow), .file_fmt_in(file_fmt),
		.stream_in(dec_stream_out), .stream_valid_in(dec_stream_valid_out),
		.ready_out(dec_stream_ready_in), .block_out(dec_block_in),
		.block_valid_out(dec_block_valid_in), .fmt_out(dec_file_format_in),
		.fmt_valid_out(dec_format_valid_in));
	// Block word count and cycle ceiling
	always @(posedge clk_in) begin
		blk_cnt <= blk_cnt + int'(enc_block_valid_out === 1'b1);
		view_cnt <= view_cnt + int'(view_valid_out === 1'b1);
		if (view_valid_out === 1'b1) view_last <= view_data_out;
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		reg_addr_in = a;
		reg_wdata_in = v;
		reg_wr_in = 1'b1;
		tick();
		reg_wr_in = 1'b0;
		tick();
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		tick();
		reg_rd_in = 1'b0;
		v = reg_rdata_out;
		tick();
	endtask
	initial begin
		repeat (2) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		tick();
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].addr, rows[i].wdata);
			end
			rd(rows[i].addr, d);
			chk("register", d & rows[i].mask, rows[i].exp);
		end
		// Each source in turn fills one 8x8 block
		for (int s = 0; s < 3; s++) begin
			wr(CONTROL_ADDR, 16'h0001 | 16'(s << CTL_SRC_LO));
			b0 = blk_cnt;
			camera_valid_in = s == 0;
			display_valid_in = s == 1;
			host_yuv_valid_in = s == 2;
			for (n = 0; n < BLOCK_SAMPLES; n++) begin
				camera_data_in = 16'(n);
				display_yuv_in = 16'(n);
				host_yuv_in = 16'(n);
				tick();
			end
			{camera_valid_in, display_valid_in, host_yuv_valid_in} = 3'h0;
			repeat (300) tick();
			chk("block words", 16'(blk_cnt - b0), 16'(BLOCK_SAMPLES));
			chk("block data", enc_block_data_out, 16'(BLOCK_SAMPLES - 1));
			wr(CONTROL_ADDR, 16'h0000);
		end
		// Encoded words leave through the data port in order
		wr(CONTROL_ADDR, 16'h0001);
		enc_stream_valid_in = 1'b1;
		for (n = 0; n < 3; n++) begin
			enc_stream_in = 16'hA000 + 16'(n);
			tick();
		end
		enc_stream_valid_in = 1'b0;
		tick();
		for (n = 0; n < 4; n++) begin
			rd(FIFO_PORT_ADDR, d);
			chk("fifo word", d, n < 3 ? 16'hA000 + 16'(n) : 16'h0000);
		end
		// raw camera words through the port
		wr(CONTROL_ADDR, 16'h0005);
		camera_valid_in = 1'b1;
		for (n = 0; n < 2; n++) begin
			camera_data_in = 16'hC000 + 16'(n);
			tick();
		end
		camera_valid_in = 1'b0;
		tick();
		for (n = 0; n < 2; n++) begin
			rd(FIFO_PORT_ADDR, d);
			chk("raw word", d, 16'hC000 + 16'(n));
		end
		image_width_in = MAX_WIDTH_422 + 12'h001;
		tick();
		chk("width error", {15'h0, width_error_out}, 16'h0001);
		image_width_in = MAX_WIDTH_422;
		tick();
		chk("width error", {15'h0, width_error_out}, 16'h0000);
		wr(FORMAT_ADDR, {14'h0, FMT_444});
		chk("format error", {15'h0, format_error_out}, 16'h0001);
		wr(INT_EN_ADDR, 16'h0001);
		chk("irq", {15'h0, irq_out}, 16'h0001);
		wr(INT_EN_ADDR, 16'h0000);
		chk("irq", {15'h0, irq_out}, 16'h0000);
		// Decode with a host pause before the end marker
		wr(FORMAT_ADDR, {14'h0, FMT_422});
		wr(CONTROL_ADDR, 16'h0000);
		wr(CONTROL_ADDR, 16'h0003);
		b0 = blk_cnt;
		foreach (dec_words[i]) begin
			slow = i > 0;
			wr(FIFO_PORT_ADDR, dec_words[i]);
			if (i == 1) begin
				repeat (20) tick();
			end
		end
		repeat (40) tick();
		chk("words taken", 16'(u_dec.got_q.size()), 16'h0003);
		foreach (u_dec.got_q[i]) begin
			chk("stream word", u_dec.got_q[i], dec_words[i]);
		end
		rd(FORMAT_ADDR, d);
		chk("file format", d & 16'h0003, {14'h0, FMT_444});
		rd(STATUS_ADDR, d);
		chk("done flag", d & 16'h0008, 16'h0008);
		chk("view words", 16'(view_cnt), 16'h0003);
		chk("view data", view_last, EOF_MARKER ^ 16'h5A5A);
		chk("encoder idle", 16'(blk_cnt - b0), 16'h0000);
		// Mid-run reset returns registers to their reset values
		reset_in = 1'b1;
		tick();
		reset_in = 1'b0;
		chk("reset read data", reg_rdata_out, 16'h0000);
		chk("reset stream valid", {15'h0, dec_stream_valid_out}, 16'h0000);
		tick();
		rd(FIFO_SIZE_ADDR, d);
		chk("reset size", d, FIFO_SIZE_RESET);
		rd(STATUS_ADDR, d);
		chk("reset done flag", d & 16'h0008, 16'h0000);
		end_sim();
	end
endmodule
bind codec_fifo_control codec_checker u_chk (
	.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .image_width_in(image_width_in),
	.dec_stream_out(dec_stream_out), .dec_stream_valid_out(dec_stream_valid_out),
	.dec_stream_ready_in(dec_stream_ready_in), .dec_file_format_in(dec_file_format_in),
	.dec_format_valid_in(dec_format_valid_in), .enc_format_out(enc_format_out),
	.format_error_out(format_error_out), .width_error_out(width_error_out));
